// ==== core/ifer_core.sv ====
// interrupt flag and enable registers behind an apb slave
//
// How it works
// - enable bit 1 gates the shared pwm one-to-five interrupt
// - enable bit 0 gates the pwm zero interrupt
// - pwm requests also need the global pwm interrupt enable
// - port 3, 1, 0 change flags at bits 3,1,0; write 0 clears
// - pwm group flag set at pwm1 period end; writing 1h clears it
// - pwm zero flag set at pwm0 period end; writing 2h clears it
// - timer b overflow flag bit 7, cleared on vectoring
// - timer a overflow flag bit 5, cleared on vectoring
// - run bits 6 and 4 let timers b and a count
// - ext irq b flag bit 3 set on pin falling edge, cleared on vectoring
// - ext irq a flag bit 1 set on pin falling edge, cleared on vectoring
// - bit 2 picks low level (0) or falling edge (1) for ext irq b
// - bit 0 picks low level (0) or falling edge (1) for ext irq a
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module ifer_core
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pwm_group_period_end,
   input wire logic pwm_zero_period_end,
   input wire logic [2:0] port_change_event,
   input wire logic timer_b_overflow,
   input wire logic timer_a_overflow,
   input wire logic ext_irq_b_pin,
   input wire logic ext_irq_a_pin,
   input wire logic ack_timer_b,
   input wire logic ack_timer_a,
   input wire logic ack_ext_b,
   input wire logic ack_ext_a,
   output logic timer_b_run,
   output logic timer_a_run,
   output logic req_pwm,
   output logic req_port,
   output logic req_timer_b,
   output logic req_timer_a,
   output logic req_ext_b,
   output logic req_ext_a,
   output logic irq
);
   logic [7:0] pwm_irq_enable_r;
   logic [7:0] port_change_flags_r;
   logic [7:0] pwm_irq_flags_r;
   logic [7:0] tec_r;
   logic [7:0] gctrl_r;
   logic [8:0] stat_r;
   logic [8:0] mask_r;
   logic [8:0] src_evt;
   logic [8:0] stat_clr;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic ext_b_lvl;
   logic ext_b_fall;
   logic ext_a_lvl;
   logic ext_a_fall;
   logic ext_b_req;
   logic ext_a_req;
   logic pwm_req_nxt;
   logic [7:0] port_set;
   logic [31:0] rd_nxt;

   ifer_pin_sync u_sync_b
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(ext_irq_b_pin),
      .level(ext_b_lvl),
      .fall(ext_b_fall)
   );

   ifer_pin_sync u_sync_a
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(ext_irq_a_pin),
      .level(ext_a_lvl),
      .fall(ext_a_fall)
   );

   // zero wait state slave: access phase always completes
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   always_comb
   begin
      addr_ok = 1'b1;
      case (paddr)
         ifer_pkg::ADDR_PWM_IRQ_ENABLE: rd_nxt = {24'h000000, pwm_irq_enable_r};
         ifer_pkg::ADDR_PORT_CHANGE_FLAGS: rd_nxt = {24'h000000, port_change_flags_r};
         ifer_pkg::ADDR_PWM_IRQ_FLAGS: rd_nxt = {24'h000000, pwm_irq_flags_r};
         ifer_pkg::ADDR_TIMER_EXTINT_CONTROL: rd_nxt = {24'h000000, tec_r};
         ifer_pkg::ADDR_GLOBAL_CTRL: rd_nxt = {24'h000000, gctrl_r};
         ifer_pkg::ADDR_IRQ_STATUS: rd_nxt = {23'h000000, stat_r};
         ifer_pkg::ADDR_IRQ_MASK: rd_nxt = {23'h000000, mask_r};
         default:
         begin
            rd_nxt = 32'h00000000;
            addr_ok = 1'b0;
         end
      endcase
   end

   // read data captured in setup so it comes from a flop in the access phase
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         prdata <= 32'h00000000;
      else if (rd_en)
         prdata <= rd_nxt;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pwm_irq_enable_r <= ifer_pkg::RESET_BYTE;
         gctrl_r <= ifer_pkg::RESET_BYTE;
         mask_r <= ifer_pkg::RESET_SRC;
      end
      else if (wr_en)
      begin
         if (paddr == ifer_pkg::ADDR_PWM_IRQ_ENABLE)
            pwm_irq_enable_r <= pwdata[7:0] & 8'h03;
         if (paddr == ifer_pkg::ADDR_GLOBAL_CTRL)
            gctrl_r <= pwdata[7:0] & 8'h01;
         if (paddr == ifer_pkg::ADDR_IRQ_MASK)
            mask_r <= pwdata[8:0];
      end
   end

   // change flags: event set wins over a zero write
   always_comb
   begin
      port_set = 8'h00;
      port_set[ifer_pkg::PORT3_CHANGE_FLAG_BIT] = port_change_event[2];
      port_set[ifer_pkg::PORT1_CHANGE_FLAG_BIT] = port_change_event[1];
      port_set[ifer_pkg::PORT0_CHANGE_FLAG_BIT] = port_change_event[0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         port_change_flags_r <= ifer_pkg::RESET_BYTE;
      else if (wr_en && paddr == ifer_pkg::ADDR_PORT_CHANGE_FLAGS)
         port_change_flags_r <= ((port_change_flags_r & pwdata[7:0]) | port_set)
            & ifer_pkg::PORT_FLAG_MASK;
      else
         port_change_flags_r <= port_change_flags_r | port_set;
   end

   // code clears, period end sets and wins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pwm_irq_flags_r <= ifer_pkg::RESET_BYTE;
      end
      else
      begin
         if (pwm_group_period_end)
            pwm_irq_flags_r[ifer_pkg::PWM_GROUP_PERIOD_FLAG_BIT] <= 1'b1;
         else if (wr_en && paddr == ifer_pkg::ADDR_PWM_IRQ_FLAGS
            && pwdata[7:0] == ifer_pkg::PWM_GROUP_CLEAR_CODE)
            pwm_irq_flags_r[ifer_pkg::PWM_GROUP_PERIOD_FLAG_BIT] <= 1'b0;
         if (pwm_zero_period_end)
            pwm_irq_flags_r[ifer_pkg::PWM_ZERO_PERIOD_FLAG_BIT] <= 1'b1;
         else if (wr_en && paddr == ifer_pkg::ADDR_PWM_IRQ_FLAGS
            && pwdata[7:0] == ifer_pkg::PWM_ZERO_CLEAR_CODE)
            pwm_irq_flags_r[ifer_pkg::PWM_ZERO_PERIOD_FLAG_BIT] <= 1'b0;
      end
   end

   // timer and external flags: hardware set first, then vector clear, then software write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tec_r <= ifer_pkg::RESET_BYTE;
      end
      else
      begin
         // run and trigger bits are software owned
         if (wr_en && paddr == ifer_pkg::ADDR_TIMER_EXTINT_CONTROL)
            tec_r <= pwdata[7:0];
         if (timer_b_overflow)
            tec_r[ifer_pkg::TIMER_B_OVERFLOW_FLAG_BIT] <= 1'b1;
         else if (ack_timer_b)
            tec_r[ifer_pkg::TIMER_B_OVERFLOW_FLAG_BIT] <= 1'b0;
         if (timer_a_overflow)
            tec_r[ifer_pkg::TIMER_A_OVERFLOW_FLAG_BIT] <= 1'b1;
         else if (ack_timer_a)
            tec_r[ifer_pkg::TIMER_A_OVERFLOW_FLAG_BIT] <= 1'b0;
         // ext b falling edge flag
         // falls latch in level mode too; there the flag raises no request
         if (ext_b_fall)
            tec_r[ifer_pkg::EXT_IRQ_B_FLAG_BIT] <= 1'b1;
         else if (ack_ext_b)
            tec_r[ifer_pkg::EXT_IRQ_B_FLAG_BIT] <= 1'b0;
         if (ext_a_fall)
            tec_r[ifer_pkg::EXT_IRQ_A_FLAG_BIT] <= 1'b1;
         else if (ack_ext_a)
            tec_r[ifer_pkg::EXT_IRQ_A_FLAG_BIT] <= 1'b0;
      end
   end

   // level mode follows the pin, edge mode the flag
   assign ext_b_req = tec_r[ifer_pkg::EXT_IRQ_B_EDGE_SEL_BIT]
      ? tec_r[ifer_pkg::EXT_IRQ_B_FLAG_BIT] : ~ext_b_lvl;
   assign ext_a_req = tec_r[ifer_pkg::EXT_IRQ_A_EDGE_SEL_BIT]
      ? tec_r[ifer_pkg::EXT_IRQ_A_FLAG_BIT] : ~ext_a_lvl;

   assign pwm_req_nxt = gctrl_r[ifer_pkg::PWM_GLOBAL_IRQ_EN_BIT]
      & ((pwm_irq_enable_r[ifer_pkg::PWM_GROUP_IRQ_EN_BIT]
         & pwm_irq_flags_r[ifer_pkg::PWM_GROUP_PERIOD_FLAG_BIT])
      | (pwm_irq_enable_r[ifer_pkg::PWM_ZERO_IRQ_EN_BIT]
         & pwm_irq_flags_r[ifer_pkg::PWM_ZERO_PERIOD_FLAG_BIT]));

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         req_pwm <= 1'b0;
         req_port <= 1'b0;
         req_timer_b <= 1'b0;
         req_timer_a <= 1'b0;
         req_ext_b <= 1'b0;
         req_ext_a <= 1'b0;
         timer_b_run <= 1'b0;
         timer_a_run <= 1'b0;
      end
      else
      begin
         req_pwm <= pwm_req_nxt;
         req_port <= |port_change_flags_r;
         req_timer_b <= tec_r[ifer_pkg::TIMER_B_OVERFLOW_FLAG_BIT];
         req_timer_a <= tec_r[ifer_pkg::TIMER_A_OVERFLOW_FLAG_BIT];
         req_ext_b <= ext_b_req;
         req_ext_a <= ext_a_req;
         timer_b_run <= tec_r[ifer_pkg::TIMER_B_RUN_BIT];
         timer_a_run <= tec_r[ifer_pkg::TIMER_A_RUN_BIT];
      end
   end

   // sticky event status: bit order pwm group, pwm zero, port0, port1, port3,
   // timer b, timer a, ext b edge, ext a edge
   assign src_evt = {ext_a_fall, ext_b_fall, timer_a_overflow, timer_b_overflow,
      port_change_event, pwm_zero_period_end, pwm_group_period_end};
   assign stat_clr = (wr_en && paddr == ifer_pkg::ADDR_IRQ_STATUS) ? pwdata[8:0] : 9'h000;

   genvar gi;
   generate
      for (gi = 0; gi < ifer_pkg::NUM_SRC; gi = gi + 1)
      begin : g_stat
         // set beats the write-one clear in the same cycle
         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               stat_r[gi] <= 1'b0;
            end
            else if (src_evt[gi])
            begin
               stat_r[gi] <= 1'b1;
            end
            else if (stat_clr[gi])
            begin
               stat_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(stat_r & mask_r);
      end
   end

   // no pwm request without global enable
   a_pwm_global_gate: assert property (@(posedge clk_sys) disable iff (rst)
      !gctrl_r[0] |=> !req_pwm)
      else $error("pwm request without global enable");
   // group flag with both enables raises request
   a_pwm_group_req: assert property (@(posedge clk_sys) disable iff (rst)
      (gctrl_r[0] && pwm_irq_enable_r[1] && pwm_irq_flags_r[1]) |=> req_pwm)
      else $error("pwm group request missing");
   // zero flag blocked when its enable is low
   a_pwm_zero_block: assert property (@(posedge clk_sys) disable iff (rst)
      (!pwm_irq_enable_r[0] && !(pwm_irq_enable_r[1] && pwm_irq_flags_r[1])) |=> !req_pwm)
      else $error("pwm zero request while disabled");
   // port event is visible next cycle
   a_port_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
      port_change_event[2] |=> port_change_flags_r[3])
      else $error("port3 change flag not set");
   // clear code 1h clears the group flag
   a_pwm_group_clr: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_en && paddr == ifer_pkg::ADDR_PWM_IRQ_FLAGS && !pwm_group_period_end
         && pwdata[7:0] == ifer_pkg::PWM_GROUP_CLEAR_CODE) |=> !pwm_irq_flags_r[1])
      else $error("pwm group flag not cleared by 1h");
   // period end sets the zero flag
   a_pwm_zero_set: assert property (@(posedge clk_sys) disable iff (rst)
      pwm_zero_period_end |=> pwm_irq_flags_r[0])
      else $error("pwm zero flag not set");
   // ack without overflow clears flag, request follows
   a_timer_b_ack: assert property (@(posedge clk_sys) disable iff (rst)
      (ack_timer_b && !timer_b_overflow) |=> !tec_r[7] ##1 !req_timer_b)
      else $error("timer b flag not cleared on vectoring");
   a_timer_a_set: assert property (@(posedge clk_sys) disable iff (rst)
      timer_a_overflow |=> tec_r[5] ##1 req_timer_a)
      else $error("timer a overflow not flagged");
   // timer b run output follows its control bit
   a_run_follow: assert property (@(posedge clk_sys) disable iff (rst)
      ##1 timer_b_run == $past(tec_r[6]))
      else $error("timer b run does not follow control");
   // level mode requests while pin is low
   a_ext_b_level: assert property (@(posedge clk_sys) disable iff (rst)
      (!tec_r[2] && !ext_b_lvl) |=> req_ext_b)
      else $error("ext b level request missing");
   // edge mode with clear flag gives no request
   a_ext_a_edge: assert property (@(posedge clk_sys) disable iff (rst)
      (tec_r[0] && !tec_r[1]) |=> !req_ext_a)
      else $error("ext a edge mode request without flag");
   a_ext_edge_set: assert property (@(posedge clk_sys) disable iff (rst)
      (ext_b_fall |=> tec_r[3]) and (ext_a_fall |=> tec_r[1]))
      else $error("external edge flag not set");
endmodule

// ==== pkg/ifer_pkg.sv ====
// constants for the interrupt flag and enable register block
package ifer_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_PWM_IRQ_ENABLE = 8'h84;
   localparam logic [7:0] IDX_PORT_CHANGE_FLAGS = 8'h85;
   localparam logic [7:0] IDX_PWM_IRQ_FLAGS = 8'h86;
   localparam logic [7:0] IDX_TIMER_EXTINT_CONTROL = 8'h88;
   // own registers
   localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h90;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h91;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h92;
   localparam logic [11:0] ADDR_PWM_IRQ_ENABLE = 12'h210;
   localparam logic [11:0] ADDR_PORT_CHANGE_FLAGS = 12'h214;
   localparam logic [11:0] ADDR_PWM_IRQ_FLAGS = 12'h218;
   localparam logic [11:0] ADDR_TIMER_EXTINT_CONTROL = 12'h220;
   localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'h240;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h244;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h248;
   // pwm_irq_enable fields
   localparam int PWM_GROUP_IRQ_EN_BIT = 1;
   localparam int PWM_ZERO_IRQ_EN_BIT = 0;
   // port_change_flags fields
   localparam int PORT3_CHANGE_FLAG_BIT = 3;
   localparam int PORT1_CHANGE_FLAG_BIT = 1;
   localparam int PORT0_CHANGE_FLAG_BIT = 0;
   localparam logic [7:0] PORT_FLAG_MASK = 8'h0B;
   // pwm_irq_flags fields and clear codes
   localparam int PWM_GROUP_PERIOD_FLAG_BIT = 1;
   localparam int PWM_ZERO_PERIOD_FLAG_BIT = 0;
   localparam logic [7:0] PWM_GROUP_CLEAR_CODE = 8'h01;
   localparam logic [7:0] PWM_ZERO_CLEAR_CODE = 8'h02;
   // timer_extint_control fields
   localparam int TIMER_B_OVERFLOW_FLAG_BIT = 7;
   localparam int TIMER_B_RUN_BIT = 6;
   localparam int TIMER_A_OVERFLOW_FLAG_BIT = 5;
   localparam int TIMER_A_RUN_BIT = 4;
   localparam int EXT_IRQ_B_FLAG_BIT = 3;
   localparam int EXT_IRQ_B_EDGE_SEL_BIT = 2;
   localparam int EXT_IRQ_A_FLAG_BIT = 1;
   localparam int EXT_IRQ_A_EDGE_SEL_BIT = 0;
   // global control field
   localparam int PWM_GLOBAL_IRQ_EN_BIT = 0;
   // interrupt status layout: one bit per event source
   localparam int NUM_SRC = 9;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [8:0] RESET_SRC = 9'h000;
   localparam int SYNC_STAGES = 2;
endpackage

// ==== core/ifer_pin_sync.sv ====
// two-stage synchroniser with falling-edge detect for an external pin
`timescale 1ns/1ps
module ifer_pin_sync
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end
      else
      begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign fall = prev_r & ~sync_r;

   a_fall_from_sync: assert property (@(posedge clk_sys) disable iff (rst)
      fall |-> ($past(sync_r) && !sync_r))
      else $error("fall seen without synchronised high to low");
endmodule

// ==== tb/ifer_cpu_model.sv ====
// cpu core stand-in that acknowledges timer and external interrupt requests
`timescale 1ns/1ps
module ifer_cpu_model
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic en,
   input wire logic [1:0] lat,
   input wire logic req_timer_b,
   input wire logic req_timer_a,
   input wire logic req_ext_b,
   input wire logic req_ext_a,
   output logic ack_timer_b,
   output logic ack_timer_a,
   output logic ack_ext_b,
   output logic ack_ext_a
);
   logic [3:0] wait_r;
   logic [3:0] pend;
   assign pend = {req_timer_b, req_timer_a, req_ext_b, req_ext_a};
   // one vector pulse per source
   // at least four cycles between pulses, so a request still lagging its
   // cleared flag is never acknowledged twice
   always_ff @(posedge clk_sys)
   begin
      {ack_timer_b, ack_timer_a, ack_ext_b, ack_ext_a} <= 4'h0;
      if (rst || !en || pend == 4'h0)
         wait_r <= 4'h0;
      else if (wait_r == {2'b00, lat} + 4'h4)
      begin
         wait_r <= 4'h0;
         {ack_timer_b, ack_timer_a, ack_ext_b, ack_ext_a} <= pend & (~pend + 4'h1);
      end
      else
         wait_r <= wait_r + 4'h1;
   end
endmodule

// ==== tb/tb_irq_flag_enable_regs.sv ====
// self-checking bench for the interrupt flag and enable registers
`timescale 1ns/1ps
module tb_irq_flag_enable_regs;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] ev_in;
   logic pin_b, pin_a, cpu_en, e;
   logic [1:0] cpu_lat;
   logic ack_tb, ack_ta, ack_eb, ack_ea, run_b, run_a;
   logic req_pwm, req_port, req_tb, req_ta, req_eb, req_ea;
   logic [7:0] v, exp;
   logic [2:0] pe;
   int error_cnt, samples_checked, seed;

   ifer_core i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwm_group_period_end(ev_in[6]), .pwm_zero_period_end(ev_in[5]),
      .port_change_event(ev_in[4:2]), .timer_b_overflow(ev_in[1]),
      .timer_a_overflow(ev_in[0]), .ext_irq_b_pin(pin_b), .ext_irq_a_pin(pin_a),
      .ack_timer_b(ack_tb), .ack_timer_a(ack_ta), .ack_ext_b(ack_eb), .ack_ext_a(ack_ea),
      .timer_b_run(run_b), .timer_a_run(run_a), .req_pwm(req_pwm), .req_port(req_port),
      .req_timer_b(req_tb), .req_timer_a(req_ta), .req_ext_b(req_eb), .req_ext_a(req_ea),
      .irq(irq));

   ifer_cpu_model i_cpu (.clk_sys(clk_sys), .rst(rst), .en(cpu_en), .lat(cpu_lat),
      .req_timer_b(req_tb), .req_timer_a(req_ta), .req_ext_b(req_eb), .req_ext_a(req_ea),
      .ack_timer_b(ack_tb), .ack_timer_a(ack_ta), .ack_ext_b(ack_eb), .ack_ext_a(ack_ea));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
      samples_checked++;
      if (got !== expv)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, expv, got);
      end
   endtask

   task automatic chkb(input string name, input logic expv, input logic got);
      samples_checked++;
      if (got !== expv)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", name, expv, got);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic er;
      apb(1'b1, a, d, q, er);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] expv, input logic [31:0] m);
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk($sformatf("read %h", a), expv & m, rd & m);
      chkb("slave error", 1'b0, er);
   endtask

   task automatic pulse(input logic [6:0] m);
      @(posedge clk_sys);
      ev_in <= m;
      @(posedge clk_sys);
      ev_in <= 7'h00;
   endtask

   function automatic logic [7:0] port_map(input logic [2:0] p);
      return {4'h0, p[2], 1'b0, p[1], p[0]};
   endfunction

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end

   initial
   begin
      seed = 32'h728a8408;
      {psel, penable, pwrite, paddr, pwdata, ev_in} = '0;
      {pin_b, pin_a, cpu_en, cpu_lat, error_cnt, samples_checked} = '0;
      pin_b = 1'b1;
      pin_a = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(ifer_pkg::ADDR_PWM_IRQ_ENABLE, 32'h0, 32'hFFFFFFFF);
      rdc(ifer_pkg::ADDR_PORT_CHANGE_FLAGS, 32'h0, 32'hFFFFFFFF);
      rdc(ifer_pkg::ADDR_PWM_IRQ_FLAGS, 32'h0, 32'hFFFFFFFF);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h0, 32'hFFFFFFFF);
      rdc(ifer_pkg::ADDR_IRQ_STATUS, 32'h0, 32'hFFFFFFFF);
      apb(1'b0, 12'h3FC, 32'h0, rd, e);
      chkb("unmapped error", 1'b1, e);
      v = $random(seed);
      wr(ifer_pkg::ADDR_PWM_IRQ_ENABLE, {24'h0, v});
      rdc(ifer_pkg::ADDR_PWM_IRQ_ENABLE, {30'h0, v[1:0]}, 32'h3);
      // pwm flags: only the exact clear codes clear, each its own bit
      pulse(7'h60);
      rdc(ifer_pkg::ADDR_PWM_IRQ_FLAGS, 32'h3, 32'h3);
      wr(ifer_pkg::ADDR_PWM_IRQ_FLAGS, 32'h3);
      rdc(ifer_pkg::ADDR_PWM_IRQ_FLAGS, 32'h3, 32'h3);
      wr(ifer_pkg::ADDR_PWM_IRQ_FLAGS, {24'h0, ifer_pkg::PWM_ZERO_CLEAR_CODE});
      rdc(ifer_pkg::ADDR_PWM_IRQ_FLAGS, 32'h2, 32'h3);
      pulse(7'h20);
      wr(ifer_pkg::ADDR_PWM_IRQ_ENABLE, 32'h3);
      wr(ifer_pkg::ADDR_GLOBAL_CTRL, 32'h0);
      repeat (3) @(posedge clk_sys);
      chkb("req_pwm", 1'b0, req_pwm);
      wr(ifer_pkg::ADDR_GLOBAL_CTRL, 32'h1);
      repeat (3) @(posedge clk_sys);
      chkb("req_pwm", 1'b1, req_pwm);
      wr(ifer_pkg::ADDR_PWM_IRQ_ENABLE, 32'h1);
      wr(ifer_pkg::ADDR_PWM_IRQ_FLAGS, {24'h0, ifer_pkg::PWM_ZERO_CLEAR_CODE});
      repeat (3) @(posedge clk_sys);
      chkb("req_pwm", 1'b0, req_pwm);
      wr(ifer_pkg::ADDR_PWM_IRQ_ENABLE, 32'h2);
      repeat (3) @(posedge clk_sys);
      chkb("req_pwm", 1'b1, req_pwm);
      wr(ifer_pkg::ADDR_PWM_IRQ_FLAGS, {24'h0, ifer_pkg::PWM_GROUP_CLEAR_CODE});
      rdc(ifer_pkg::ADDR_PWM_IRQ_FLAGS, 32'h0, 32'h3);
      repeat (4)
      begin
         pe = $random(seed);
         v = $random(seed);
         pulse({2'b00, pe, 2'b00});
         exp = port_map(pe);
         rdc(ifer_pkg::ADDR_PORT_CHANGE_FLAGS, {24'h0, exp}, 32'hB);
         wr(ifer_pkg::ADDR_PORT_CHANGE_FLAGS, {24'h0, v});
         rdc(ifer_pkg::ADDR_PORT_CHANGE_FLAGS, {24'h0, exp & v}, 32'hB);
         chkb("req_port", |(exp & v & 8'h0B), req_port);
         wr(ifer_pkg::ADDR_PORT_CHANGE_FLAGS, 32'h0);
      end
      wr(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h50);
      repeat (2) @(posedge clk_sys);
      chkb("timer_b_run", 1'b1, run_b);
      wr(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h10);
      repeat (2) @(posedge clk_sys);
      chkb("timer_b_run", 1'b0, run_b);
      chkb("timer_a_run", 1'b1, run_a);
      pulse(7'h03);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'hB0, 32'hFF);
      chkb("req_timer_b", 1'b1, req_tb);
      cpu_lat <= 2'($random(seed));
      cpu_en <= 1'b1;
      repeat (30) @(posedge clk_sys);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h10, 32'hFF);
      chkb("req_timer_b", 1'b0, req_tb);
      cpu_en <= 1'b0;
      // edge mode on both pins, flags sticky until vectoring
      wr(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h05);
      pin_b <= 1'b0;
      pin_a <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h0F, 32'hFF);
      chkb("req_ext_b", 1'b1, req_eb);
      pin_b <= 1'b1;
      pin_a <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h0F, 32'hFF);
      cpu_en <= 1'b1;
      repeat (30) @(posedge clk_sys);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h05, 32'hFF);
      cpu_en <= 1'b0;
      // level mode: requests follow the pins, falls still latch the flags
      wr(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h0);
      pin_b <= 1'b0;
      pin_a <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chkb("req_ext_a", 1'b1, req_ea);
      chkb("req_ext_b", 1'b1, req_eb);
      rdc(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h0A, 32'h0A);
      pin_b <= 1'b1;
      pin_a <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chkb("req_ext_a", 1'b0, req_ea);
      chkb("req_ext_b", 1'b0, req_eb);
      // status is write-one-to-clear, irq follows status and mask
      wr(ifer_pkg::ADDR_IRQ_STATUS, 32'h1FF);
      wr(ifer_pkg::ADDR_IRQ_MASK, 32'h0);
      pulse(7'h01);
      repeat (3) @(posedge clk_sys);
      chkb("irq masked", 1'b0, irq);
      rdc(ifer_pkg::ADDR_IRQ_STATUS, 32'h40, 32'h1FF);
      wr(ifer_pkg::ADDR_IRQ_MASK, 32'h40);
      repeat (3) @(posedge clk_sys);
      chkb("irq", 1'b1, irq);
      wr(ifer_pkg::ADDR_TIMER_EXTINT_CONTROL, 32'h0);
      wr(ifer_pkg::ADDR_IRQ_STATUS, 32'h40);
      repeat (3) @(posedge clk_sys);
      chkb("irq cleared", 1'b0, irq);
      wrap_up();
   end
endmodule
